// [dv/far_side_model.sv]
// Stand-in for the cluster caches and interconnect seen by atomic routing.
// Assumes the bench picks snoop hit and line loss through mode.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    input  wire logic [1:0] mode,
    output wire logic       cluster_hit,
    output wire logic       line_lost
);
    assign cluster_hit = mode[0];
    assign line_lost   = mode[1];
endmodule
`default_nettype wire

// [dv/l1_policy_props.sv]
// Checker for the L1 data memory policy block, bound to its top ports.
// Assumes every answer lands exactly one cycle after its request pulse.
`timescale 1ns/1ps
`default_nettype none
module l1_policy_chk (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        atom_req,
    input wire logic        atom_valid,
    input wire logic        pf_req,
    input wire logic        pf_hit,
    input wire logic        pf_cacheable,
    input wire logic        pf_linefill,
    input wire logic        pf_retire,
    input wire logic        evict_l1,
    input wire logic        evict_l1_transient,
    input wire logic        l2_no_retain,
    input wire logic        evict_l2,
    input wire logic        evict_l2_transient,
    input wire logic        l3_bypass,
    input wire logic        excl_st,
    input wire logic        excl_st_done,
    input wire logic        hpf_valid,
    input wire logic        hpf_is_virtual,
    input wire logic        hpf_to_l1,
    input wire logic        zero_req,
    input wire logic [47:0] zero_vaddr,
    input wire logic        zero_valid,
    input wire logic [47:0] zero_base
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    AST_ZERO_BASE: assert property (zero_req |=> zero_valid && zero_base == {$past(zero_vaddr[47:6]), 6'h00})
        else $error("block zero base wrong");
    AST_PF_FILL: assert property (pf_req && !pf_hit && pf_cacheable |=> pf_linefill && pf_retire)
        else $error("prefetch miss without linefill");
    AST_PF_NO_FILL: assert property (pf_req && (pf_hit || !pf_cacheable) |=> !pf_linefill)
        else $error("prefetch filled on hit or uncached");
    AST_L2_HINT: assert property (evict_l1 |=> l2_no_retain == $past(evict_l1_transient))
        else $error("transient hint not passed to L2");
    AST_L3_SKIP: assert property (evict_l2 |=> l3_bypass == $past(evict_l2_transient))
        else $error("L3 bypass wrong on L2 eviction");
    AST_ST_PF_L2: assert property (hpf_valid && !hpf_is_virtual |-> !hpf_to_l1)
        else $error("store prefetch aimed at L1");
    AST_EXCL_ANS: assert property (excl_st |=> excl_st_done)
        else $error("store exclusive got no answer");
    AST_ATOM_ANS: assert property (atom_req |=> atom_valid ##1 !atom_valid || $past(atom_req))
        else $error("atomic answer missing or stuck");
endmodule
bind l1_data_mem_policy l1_policy_chk u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .atom_req(atom_req),
    .atom_valid(atom_valid), .pf_req(pf_req), .pf_hit(pf_hit), .pf_cacheable(pf_cacheable),
    .pf_linefill(pf_linefill), .pf_retire(pf_retire), .evict_l1(evict_l1), .evict_l1_transient(evict_l1_transient),
    .l2_no_retain(l2_no_retain), .evict_l2(evict_l2), .evict_l2_transient(evict_l2_transient),
    .l3_bypass(l3_bypass), .excl_st(excl_st), .excl_st_done(excl_st_done), .hpf_valid(hpf_valid),
    .hpf_is_virtual(hpf_is_virtual), .hpf_to_l1(hpf_to_l1), .zero_req(zero_req), .zero_vaddr(zero_vaddr),
    .zero_valid(zero_valid), .zero_base(zero_base));
`default_nettype wire

// [dv/test_l1_data_mem_policy.sv]
// Self-checking bench for the L1 data memory policy block.
// Assumes zero-wait APB and answers one cycle after each request pulse.
`timescale 1ns/1ps
`default_nettype none
`include "l1_policy_map.vh"
module test_l1_data_mem_policy;
    logic        ref_clk = 1'b0, arst_n, psel, penable, pwrite, pready, pslverr, slv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  atom_kind, far_mode;
    logic [2:0]  atom_route;
    logic [39:0] excl_addr, hpf_st_paddr;
    logic [47:0] hpf_ld_vaddr, hpf_addr, zero_vaddr, zero_base;
    logic atom_req, atom_cacheable, atom_l1_hit, atom_l1_unique, atom_cluster_hit, atom_line_lost, atom_fill;
    logic atom_valid, fill_req, fill_transient, fill_nontemporal, fill_load, fill_alloc_l1, fill_mark_transient;
    logic evict_l1, evict_l1_transient, l2_no_retain, evict_l2, evict_l2_transient, l3_bypass, excl_ld, excl_st;
    logic excl_clr, excl_st_ok, excl_st_done, pf_req, pf_hit, pf_cacheable, pf_linefill, pf_retire, ipl_req;
    logic ipl_cacheable, ipl_l1i_hit, ipl_l2_hit, ipl_l2_fill, hpf_ld_req, hpf_st_req, hpf_valid, hpf_is_virtual;
    logic hpf_to_l1, zero_req, zero_valid;
    int   err_count = 0, num_checks = 0;
    l1_data_mem_policy i_dut (.*);
    far_side_model u_far (.mode(far_mode), .cluster_hit(atom_cluster_hit), .line_lost(atom_line_lost));
    always #2.5 ref_clk = ~ref_clk;
    task chk(input string n, input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask
    // Drops every request pulse at the answering edge, then lets outputs settle
    task nxt;
        @(posedge ref_clk);
        {atom_req, fill_req, evict_l1, evict_l2, excl_ld, excl_st, excl_clr, pf_req, ipl_req, hpf_ld_req,
            hpf_st_req, zero_req} <= '0;
        #1;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        // Sample at the completing edge itself, before that edge's own updates land
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task atom(input logic [1:0] k, input logic [2:0] lv, input logic [1:0] fm, input logic [2:0] exp);
        @(posedge ref_clk);
        {far_mode, atom_kind, atom_cacheable, atom_l1_hit, atom_l1_unique, atom_req} <= {fm, k, lv, 1'b1};
        nxt;
        chk("atom_valid", atom_valid, 1'b1);
        chk("atom_route", atom_route, exp);
    endtask
    task excl(input logic [2:0] op, input logic [39:0] a);
        @(posedge ref_clk);
        {excl_ld, excl_st, excl_clr, excl_addr} <= {op, a};
        nxt;
    endtask
    task s_regs;
        apb(1'b0, `REG_CTRL_OFF, 32'h0);
        chk("ctrl reset", rd, `CTRL_RESET);
        apb(1'b0, `REG_ISA_FEAT_OFF, 32'h0);
        chk("isa feature", rd[23:20], 4'h1);
        chk("mapped no error", slv, 1'b0);
        apb(1'b0, `REG_CACHE_TYPE_OFF, 32'h0);
        chk("granule", rd[23:20], 4'h4);
        apb(1'b1, `REG_LOR_BASE_OFF + 12'h00C, 32'hA5A5_0003);
        apb(1'b0, `REG_LOR_BASE_OFF + 12'h00C, 32'h0);
        chk("region desc 3", rd, 32'hA5A5_0003);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped error", slv, 1'b1);
    endtask
    task s_atoms;
        atom(2'h1, 3'h7, 2'h1, `ATOM_NEAR);
        atom(2'h1, 3'h4, 2'h0, `ATOM_FAR_L3);
        atom(2'h1, 3'h0, 2'h0, `ATOM_ABORT);
        apb(1'b1, `REG_CTRL_OFF, 32'h0000_0010);
        atom(2'h2, 3'h4, 2'h0, `ATOM_FAR_ICN);
        atom(2'h0, 3'h6, 2'h1, `ATOM_FAR_L3);
        atom(2'h0, 3'h0, 2'h0, `ATOM_ICN_NC);
        apb(1'b1, `REG_CTRL_OFF, 32'h0000_002F);
        atom(2'h1, 3'h4, 2'h0, `ATOM_FAR_L3_ALLOC);
        atom(2'h2, 3'h6, 2'h1, `ATOM_NEAR);
        atom(2'h3, 3'h4, 2'h0, `ATOM_NEAR);
        chk("atom fill", atom_fill, 1'b1);
        apb(1'b1, `REG_CTRL_OFF, 32'h0000_00DF);
        atom(2'h3, 3'h4, 2'h2, `ATOM_FAR_ICN);
    endtask
    task s_lines;
        @(posedge ref_clk);
        {fill_req, fill_transient, fill_nontemporal, fill_load} <= 4'hC;
        nxt;
        chk("alloc l1", {fill_alloc_l1, fill_mark_transient}, 2'h3);
        {fill_req, fill_transient, fill_nontemporal, fill_load} <= 4'hB;
        nxt;
        chk("nontemporal mark", fill_mark_transient, 1'b1);
        {evict_l1, evict_l1_transient, evict_l2, evict_l2_transient} <= 4'hF;
        nxt;
        chk("evict hints", {l2_no_retain, l3_bypass}, 2'h3);
        {evict_l2, evict_l2_transient} <= 2'h2;
        nxt;
        chk("plain l2 evict", l3_bypass, 1'b0);
        excl(3'h4, 40'h12_3456_7840);
        excl(3'h2, 40'h12_3456_787C);
        chk("excl same line", {excl_st_done, excl_st_ok}, 2'h3);
        excl(3'h2, 40'h12_3456_7840);
        chk("excl when open", excl_st_ok, 1'b0);
        excl(3'h4, 40'h12_3456_7840);
        excl(3'h2, 40'h12_3456_7880);
        chk("excl other line", excl_st_ok, 1'b0);
        excl(3'h4, 40'h12_3456_7840);
        excl(3'h1, 40'h12_3456_7840);
        excl(3'h2, 40'h12_3456_7840);
        chk("excl after clear", excl_st_ok, 1'b0);
    endtask
    task s_prefetch;
        {pf_req, pf_hit, pf_cacheable, ipl_req, ipl_cacheable, ipl_l1i_hit, ipl_l2_hit} <= 7'h5C;
        nxt;
        chk("pf miss", {pf_linefill, pf_retire, ipl_l2_fill}, 3'h7);
        {pf_req, pf_hit, ipl_req, ipl_l2_hit} <= 4'hF;
        nxt;
        chk("pf hit", {pf_linefill, ipl_l2_fill}, 2'h0);
        {hpf_ld_req, hpf_ld_vaddr, zero_req, zero_vaddr} <= {1'b1, 48'hABCD_1234_5678, 1'b1, 48'h0000_1234_567F};
        nxt;
        chk("load pf", {hpf_valid, hpf_is_virtual, hpf_to_l1, hpf_addr}, {3'h7, 48'hABCD_1234_5678});
        chk("zero base", {zero_valid, zero_base}, {1'b1, 48'h0000_1234_5640});
        {hpf_st_req, hpf_st_paddr} <= {1'b1, 40'h12_3456_7890};
        nxt;
        chk("store pf", {hpf_valid, hpf_is_virtual, hpf_to_l1, hpf_addr}, {3'h4, 48'h0012_3456_7890});
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        {arst_n, psel, penable, pwrite, paddr, pwdata, atom_kind, far_mode, excl_addr, hpf_st_paddr} <= '0;
        {hpf_ld_vaddr, zero_vaddr, atom_req, atom_cacheable, atom_l1_hit, atom_l1_unique, fill_req} <= '0;
        {fill_transient, fill_nontemporal, fill_load, evict_l1, evict_l1_transient, evict_l2} <= '0;
        {evict_l2_transient, excl_ld, excl_st, excl_clr, pf_req, pf_hit, pf_cacheable, ipl_req} <= '0;
        {ipl_cacheable, ipl_l1i_hit, ipl_l2_hit, hpf_ld_req, hpf_st_req, zero_req} <= '0;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        s_regs;
        s_atoms;
        s_lines;
        s_prefetch;
        tally_and_finish;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        tally_and_finish;
    end
endmodule
`default_nettype wire

// [logic/l1_data_mem_policy.v]
// L1 data memory policy: atomic placement, allocation hints, exclusive monitor,
// prefetch routing and block-zero addressing, with an APB register file.
// Assumes all request inputs are synchronous one-cycle pulses from the load/store pipe.
`include "l1_policy_map.vh"
`timescale 1ns/1ps
`default_nettype none
module l1_data_mem_policy (
    input  wire        ref_clk,
    input  wire        arst_n,
    // Register bus
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,

    // Atomic placement
    input  wire        atom_req,
    input  wire [1:0]  atom_kind,
    input  wire        atom_cacheable,
    input  wire        atom_l1_hit,
    input  wire        atom_l1_unique,
    input  wire        atom_cluster_hit,
    input  wire        atom_line_lost,
    output reg  [2:0]  atom_route,
    output reg         atom_fill,
    output reg         atom_valid,

    // Linefill allocation hints
    input  wire        fill_req,
    input  wire        fill_transient,
    input  wire        fill_nontemporal,
    input  wire        fill_load,
    output reg         fill_alloc_l1,
    output reg         fill_mark_transient,

    // Eviction hints
    input  wire        evict_l1,
    input  wire        evict_l1_transient,
    output reg         l2_no_retain,
    input  wire        evict_l2,
    input  wire        evict_l2_transient,
    output reg         l3_bypass,

    // Local exclusive monitor
    input  wire        excl_ld,
    input  wire        excl_st,
    input  wire        excl_clr,
    input  wire [39:0] excl_addr,
    output reg         excl_st_ok,
    output reg         excl_st_done,

    // Software prefetch
    input  wire        pf_req,
    input  wire        pf_hit,
    input  wire        pf_cacheable,
    output reg         pf_linefill,
    output reg         pf_retire,

    // Instruction preload
    input  wire        ipl_req,
    input  wire        ipl_cacheable,
    input  wire        ipl_l1i_hit,
    input  wire        ipl_l2_hit,
    output reg         ipl_l2_fill,

    // Hardware prefetchers
    input  wire        hpf_ld_req,
    input  wire [47:0] hpf_ld_vaddr,
    input  wire        hpf_st_req,
    input  wire [39:0] hpf_st_paddr,
    output reg         hpf_valid,
    output reg  [47:0] hpf_addr,
    output reg         hpf_is_virtual,
    output reg         hpf_to_l1,

    // Block zero
    input  wire        zero_req,
    input  wire [47:0] zero_vaddr,
    output reg         zero_valid,
    output reg  [47:0] zero_base
);
    reg  [31:0] ctrl_q;
    wire [31:0] lor_rd [0:`LOR_COUNT-1];
    wire [3:0]  lor_hit = 4'h1 << paddr[3:2];
    wire        wr_commit;
    wire        ld_near_mode;
    wire        fill_is_transient;
    wire        hpf_ld_go;
    wire        hpf_st_go;
    reg         mon_q;
    reg  [33:0] mon_gran_q;
    reg  [31:0] rdata_d;
    wire        acc     = psel & penable;
    wire        lor_sel = (paddr >= `REG_LOR_BASE_OFF) && (paddr < `REG_LOR_BASE_OFF + 12'h010)
                          && (paddr[1:0] == 2'b00);
    wire        known   = (paddr == `REG_CTRL_OFF) || (paddr == `REG_ISA_FEAT_OFF)
                          || (paddr == `REG_CACHE_TYPE_OFF) || (paddr == `REG_STATUS_OFF) || lor_sel;
    wire        near_forced;
    reg  [2:0]  route_d;
    genvar      g;

    always @* begin
        rdata_d = 32'h0000_0000;
        if (lor_sel)
            rdata_d = lor_rd[paddr[3:2]];
        else begin
            case (paddr)
                `REG_CTRL_OFF:       rdata_d = ctrl_q;
                `REG_ISA_FEAT_OFF:   rdata_d = `ISA_FEAT_VALUE;
                `REG_CACHE_TYPE_OFF: rdata_d = {8'h00, `ERG_VALUE_LOG2W, 20'h00000};
                `REG_STATUS_OFF:     rdata_d = {31'h00000000, mon_q};
                default:             rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Answer in the access cycle itself: zero wait states
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~known;
            prdata  <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h0000_0000;
        end
    end

    // A write lands only at the edge that completes the access phase
    assign wr_commit = acc & pwrite & pready;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `CTRL_RESET;
        end else if (wr_commit && paddr == `REG_CTRL_OFF) begin
            ctrl_q <= pwdata;
        end
    end

    generate
        for (g = 0; g < `LOR_COUNT; g = g + 1) begin : g_lor
            reg [31:0] desc_q;
            // Plain storage: the ordering itself is enforced further down the pipe
            always @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    desc_q <= 32'h0000_0000;
                end else if (wr_commit && lor_sel && lor_hit[g]) begin
                    desc_q <= pwdata;
                end
            end
            assign lor_rd[g] = desc_q;
        end
    endgenerate

    // Categories a..c map onto separate enables; kind 3 is plain load atomic
    assign near_forced = (atom_kind == 2'd0 && ctrl_q[`CTRL_NEAR_ST_BIT])
                       | (atom_kind == 2'd1 && ctrl_q[`CTRL_NEAR_LDST_BIT])
                       | (atom_kind == 2'd2 && ctrl_q[`CTRL_NEAR_SWP_BIT]);

    assign ld_near_mode      = atom_cacheable && atom_kind == 2'd3 && ctrl_q[`CTRL_LD_NEAR_BIT];
    assign fill_is_transient = fill_transient | (fill_nontemporal & fill_load);
    assign hpf_ld_go         = hpf_ld_req & ctrl_q[`CTRL_LPF_EN_BIT];
    assign hpf_st_go         = hpf_st_req & ctrl_q[`CTRL_SPF_EN_BIT] & ~hpf_ld_go;

    always @* begin
        if (!atom_cacheable)
            route_d = ctrl_q[`CTRL_ICN_ATOM_BIT] ? `ATOM_ICN_NC : `ATOM_ABORT;
        else if (atom_kind == 2'd3 && ctrl_q[`CTRL_LD_NEAR_BIT])
            route_d = atom_line_lost ? `ATOM_FAR_L3 : `ATOM_NEAR;
        else if (atom_l1_hit && (atom_l1_unique || near_forced))
            route_d = `ATOM_NEAR;
        else if (!atom_cluster_hit && ctrl_q[`CTRL_ICN_ATOM_BIT])
            route_d = `ATOM_FAR_ICN;
        else if (ctrl_q[`CTRL_L3_PRESENT_BIT] && !atom_cluster_hit)
            route_d = `ATOM_FAR_L3_ALLOC;
        else
            route_d = `ATOM_FAR_L3;
        if (route_d == `ATOM_FAR_L3 && atom_kind == 2'd3 && ctrl_q[`CTRL_LD_NEAR_BIT]
            && !atom_cluster_hit && ctrl_q[`CTRL_ICN_ATOM_BIT])
            route_d = `ATOM_FAR_ICN;
    end

    // Atomic placement answer; the route holds until the next atomic
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            atom_valid <= 1'b0;
            atom_route <= `ATOM_NEAR;
        end else begin
            atom_valid <= atom_req;
            if (atom_req) begin
                atom_route <= route_d;
            end
        end
    end

    // One fill per forced-near load atomic whose line is not already held
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            atom_fill <= 1'b0;
        end else begin
            atom_fill <= atom_req && ld_near_mode && !atom_l1_hit && !atom_line_lost;
        end
    end

    // Every miss allocates in L1; non-temporal stores keep normal allocation
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fill_alloc_l1       <= 1'b0;
            fill_mark_transient <= 1'b0;
        end else begin
            fill_alloc_l1       <= fill_req;
            fill_mark_transient <= fill_req & fill_is_transient;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            l2_no_retain <= 1'b0;
        end else begin
            l2_no_retain <= evict_l1 & evict_l1_transient;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            l3_bypass <= 1'b0;
        end else begin
            l3_bypass <= evict_l2 & evict_l2_transient;
        end
    end

    // Retire with the linefill start so later instructions need not wait for data
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pf_linefill <= 1'b0;
            pf_retire   <= 1'b0;
        end else begin
            pf_linefill <= pf_req & ~pf_hit & pf_cacheable;
            pf_retire   <= pf_req;
        end
    end

    // Background fill into L2 only; L1 is never touched by a preload hint
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ipl_l2_fill <= 1'b0;
        end else begin
            ipl_l2_fill <= ipl_req & ipl_cacheable & ~ipl_l1i_hit & ~ipl_l2_hit;
        end
    end

    // Load side wins a same-cycle clash; the store stream simply retries later
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hpf_valid <= 1'b0;
            hpf_to_l1 <= 1'b0;
        end else begin
            hpf_valid <= hpf_ld_go | hpf_st_go;
            hpf_to_l1 <= hpf_ld_go;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hpf_addr       <= 48'h0000_0000_0000;
            hpf_is_virtual <= 1'b0;
        end else if (hpf_ld_go) begin
            hpf_addr       <= hpf_ld_vaddr;
            hpf_is_virtual <= 1'b1;
        end else if (hpf_st_go) begin
            hpf_addr       <= {8'h00, hpf_st_paddr};
            hpf_is_virtual <= 1'b0;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            zero_valid <= 1'b0;
        end else begin
            zero_valid <= zero_req;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            zero_base <= 48'h0000_0000_0000;
        end else if (zero_req) begin
            zero_base <= {zero_vaddr[47:`LINE_OFS_BITS], 6'h00};
        end
    end

    // The answer judges the monitor as it stood before this edge
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            excl_st_ok   <= 1'b0;
            excl_st_done <= 1'b0;
        end else begin
            excl_st_done <= excl_st;
            excl_st_ok   <= excl_st && mon_q == `MON_EXCL
                            && mon_gran_q == excl_addr[39:`LINE_OFS_BITS];
        end
    end

    // Monitor granule is one 64-byte line, matching the four-way VIPT line size
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mon_q      <= `MON_OPEN;
            mon_gran_q <= 34'h000000000;
        end else if (excl_ld) begin
            mon_q      <= `MON_EXCL;
            mon_gran_q <= excl_addr[39:`LINE_OFS_BITS];
        end else if (excl_st || excl_clr) begin
            mon_q <= `MON_OPEN;
        end
    end
endmodule
`default_nettype wire

// [logic/l1_policy_map.vh]
// Constants for the L1 data memory policy block: register offsets, fields, resets.
// Assumes an APB slave with 32-bit data, one aligned word per register.
`ifndef L1_POLICY_MAP_VH
`define L1_POLICY_MAP_VH

`define REG_CTRL_OFF        12'h000
`define REG_ISA_FEAT_OFF    12'h004
`define REG_CACHE_TYPE_OFF  12'h008
`define REG_STATUS_OFF      12'h00C
`define REG_LOR_BASE_OFF    12'h010

`define CTRL_RESET          32'h0000_0000
`define CTRL_NEAR_ST_BIT    0
`define CTRL_NEAR_LDST_BIT  1
`define CTRL_NEAR_SWP_BIT   2
`define CTRL_LD_NEAR_BIT    3
`define CTRL_ICN_ATOM_BIT   4
`define CTRL_L3_PRESENT_BIT 5
`define CTRL_LPF_EN_BIT     6
`define CTRL_SPF_EN_BIT     7

`define ISA_FEAT_VALUE      32'h0010_0000
`define ERG_LSB             20
`define ERG_VALUE_LOG2W     4'h4
`define LOR_COUNT           4
`define LINE_OFS_BITS       6
`define L1_WAYS             4

`define ATOM_NEAR           3'h0
`define ATOM_FAR_ICN        3'h1
`define ATOM_FAR_L3         3'h2
`define ATOM_FAR_L3_ALLOC   3'h3
`define ATOM_ABORT          3'h4
`define ATOM_ICN_NC         3'h5

`define MON_OPEN            1'b0
`define MON_EXCL            1'b1

`endif
